// ---- rtl/sac_pkg.sv ----
// Constants, timing counts and state encoding for the converter conversion and readout logic.
package sac_pkg;

	// ****************************************************************
	// Clock and timing
	// ****************************************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_CONV_MIN_NS = 270;
	localparam int T_CONV_TYP_NS = 290;
	localparam int T_CONV_MAX_NS = 320;
	// Cycles from a strobe pin change to the sequencer acting on it: three sync stages
	// plus the edge decode. The conversion count is shortened by this much.
	localparam int PIN_LATENCY = 4;

	// Rounds a time up to whole clock cycles, never below one cycle.
	function automatic int sac_ceil_cycles(input int timeNs);
		int cycles;
		cycles = (timeNs + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (cycles < 1) ? 1 : cycles;
	endfunction

	// Rounds a time down to whole clock cycles, never below one cycle.
	function automatic int sac_floor_cycles(input int timeNs);
		int cycles;
		cycles = timeNs / CLK_PERIOD_NS;
		return (cycles < 1) ? 1 : cycles;
	endfunction

	localparam int CONV_MIN_CYCLES = sac_ceil_cycles(T_CONV_MIN_NS);
	localparam int CONV_MAX_CYCLES = sac_floor_cycles(T_CONV_MAX_NS);
	localparam int CONV_CYCLES = sac_ceil_cycles(T_CONV_TYP_NS);

	// ****************************************************************
	// Result layout
	// ****************************************************************
	localparam int RESULT_BITS = 16;
	localparam int RESULT_MSB = RESULT_BITS - 1;
	localparam int CONV_CNT_W = 6;
	localparam int BIT_CNT_W = 5;
	localparam logic [CONV_CNT_W-1:0] CONV_LAST = CONV_CNT_W'(CONV_CYCLES - PIN_LATENCY - 1);
	localparam logic [CONV_CNT_W-1:0] CONV_CNT_ZERO = 6'h00;
	localparam logic [BIT_CNT_W-1:0] BITS_FULL = BIT_CNT_W'(RESULT_BITS);
	localparam logic [BIT_CNT_W-1:0] BITS_NONE = 5'h00;
	localparam logic [RESULT_BITS-1:0] RESULT_RESET = 16'h0000;

	// ****************************************************************
	// Synchroniser
	// ****************************************************************
	localparam int SYNC_STAGES = 3;
	localparam logic [SYNC_STAGES-1:0] SYNC_RESET = 3'h0;

	// ****************************************************************
	// States
	// ****************************************************************
	typedef enum logic [1:0] {
		SAC_IDLE = 2'b00,
		SAC_CONVERT = 2'b01,
		SAC_READOUT = 2'b10
	} sac_state_t;

endpackage

// ---- rtl/sac_pins_if.sv ----
// Synchronised pin levels and edges passed from the pin synchroniser to the converter core.
`timescale 1ns/1ps
interface sac_pins_if;
	logic strobeLvl;
	logic strobeRise;
	logic selLvl;
	logic sckRise;
	logic sckFall;

	modport prod (
		output strobeLvl,
		output strobeRise,
		output selLvl,
		output sckRise,
		output sckFall
	);

	modport cons (
		input strobeLvl,
		input strobeRise,
		input selLvl,
		input sckRise,
		input sckFall
	);
endinterface

// ---- rtl/sac_pin_sync.sv ----
// Three-stage pin synchroniser with agreement filter and edge detection for the strobe and serial clock pins.
`timescale 1ns/1ps
module sac_pin_sync import sac_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Raw pins
	input wire logic convPin,
	input wire logic selPin,
	input wire logic sckPin,
	// Synchronised view
	sac_pins_if.prod pins
);

	// ****************************************************************
	// Synchroniser chains
	// ****************************************************************
	// Stage 0 is read only by stage 1; a level counts once stages 1 and 2 agree.
	logic [SYNC_STAGES-1:0] strobeChain;
	logic [SYNC_STAGES-1:0] selChain;
	logic [SYNC_STAGES-1:0] sckChain;
	logic strobeLvl;
	logic selLvl;
	logic sckLvl;

	// The select chain starts at its idle high level, so no false low level follows reset.
	always_ff @(posedge mclk) begin
		if (rst) begin
			strobeChain <= SYNC_RESET;
			selChain <= ~SYNC_RESET;
			sckChain <= SYNC_RESET;
		end else begin
			strobeChain <= {strobeChain[1:0], convPin};
			selChain <= {selChain[1:0], selPin};
			sckChain <= {sckChain[1:0], sckPin};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			strobeLvl <= 1'b0;
			selLvl <= 1'b1;
			sckLvl <= 1'b0;
		end else begin
			if (strobeChain[1] == strobeChain[2]) strobeLvl <= strobeChain[2];
			if (selChain[1] == selChain[2]) selLvl <= selChain[2];
			if (sckChain[1] == sckChain[2]) sckLvl <= sckChain[2];
		end
	end

	// ****************************************************************
	// Edges
	// ****************************************************************
	assign pins.strobeLvl = strobeLvl;
	assign pins.selLvl = selLvl;
	assign pins.strobeRise = !strobeLvl && (strobeChain[1] == strobeChain[2]) && strobeChain[2];
	assign pins.sckRise = !sckLvl && (sckChain[1] == sckChain[2]) && sckChain[2];
	assign pins.sckFall = sckLvl && (sckChain[1] == sckChain[2]) && !sckChain[2];

endmodule // sac_pin_sync

// ---- rtl/sar_adc_serial_conversion_timing.sv ----
// Conversion timer and serial result port of a 16-bit successive-approximation converter.
//
// Notes on behaviour
// - Result ready 270 to 320 ns after strobe.
// - Strobe or select low drives result MSB.
// - Each falling clock edge presents next bit.
// - Chip-select output released on strobe and select both high or end.
// - Daisy-chain input captured on rising clock edges.
`timescale 1ns/1ps
module sar_adc_serial_conversion_timing import sac_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Converter pins
	input wire logic convert_strobe,
	input wire logic serial_select_in,
	input wire logic serialClk,
	output logic serial_result_out,
	output logic serialResultOe,
	// Sampled analog value from the comparator array
	input wire logic [RESULT_BITS-1:0] sampleValue,
	// Status
	output logic conversionBusy,
	output logic resultReady,
	output logic chainModeActive
);

	// ****************************************************************
	// Pin synchronisation
	// ****************************************************************
	sac_pins_if pins();

	sac_pin_sync uPinSync (
		.mclk(mclk),
		.rst(rst),
		.convPin(convert_strobe),
		.selPin(serial_select_in),
		.sckPin(serialClk),
		.pins(pins.prod)
	);

	// ****************************************************************
	// State and storage
	// ****************************************************************
	sac_state_t state;
	sac_state_t next_state;
	logic [CONV_CNT_W-1:0] convCount;
	logic [RESULT_BITS-1:0] sampleHold;
	logic [RESULT_BITS-1:0] shiftReg;
	logic [BIT_CNT_W-1:0] bitsLeft;
	logic chainMode;
	logic chainBit;
	logic convDone;
	logic next_oe;

	assign convDone = (state == SAC_CONVERT) && (convCount == CONV_LAST);

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	// A strobe edge starts a conversion unless one is already running.
	function automatic logic startsConversion(input logic rise, input sac_state_t st);
		return rise && (st != SAC_CONVERT);
	endfunction

	// Each falling serial clock edge seen during readout moves the shifter by one bit.
	function automatic logic shiftsBit(input logic fall, input sac_state_t st);
		return fall && (st == SAC_READOUT);
	endfunction

	logic startConv;
	logic shiftStep;

	assign startConv = startsConversion(pins.strobeRise, state);
	assign shiftStep = shiftsBit(pins.sckFall, state);

	// ****************************************************************
	// Sequencer
	// ****************************************************************
	// A new strobe edge during readout aborts it; one during conversion is ignored,
	// since the sampling capacitors are already committed to the running conversion.
	always_comb begin
		next_state = state;
		case (state)
			SAC_IDLE: begin
				if (pins.strobeRise) next_state = SAC_CONVERT;
			end
			SAC_CONVERT: begin
				if (convDone) next_state = SAC_READOUT;
			end
			SAC_READOUT: begin
				if (pins.strobeRise) next_state = SAC_CONVERT;
			end
			default: begin
				next_state = SAC_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= SAC_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// ****************************************************************
	// Conversion timer
	// ****************************************************************
	// The strobe reaches the sequencer a few cycles late, so the count is trimmed by
	// that latency to keep the result inside the window measured at the strobe pin.
	always_ff @(posedge mclk) begin
		if (rst) begin
			convCount <= CONV_CNT_ZERO;
		end else if (state != SAC_CONVERT) begin
			convCount <= CONV_CNT_ZERO;
		end else if (!convDone) begin
			convCount <= convCount + 1'b1;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			sampleHold <= RESULT_RESET;
		end else if (startConv) begin
			sampleHold <= sampleValue;
		end
	end

	// ****************************************************************
	// Mode select
	// ****************************************************************
	// Select low at the strobe edge chooses daisy-chain; high chooses chip-select.
	always_ff @(posedge mclk) begin
		if (rst) begin
			chainMode <= 1'b0;
		end else if (startConv) begin
			chainMode <= !pins.selLvl;
		end
	end

	// ****************************************************************
	// Serial shifter
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			chainBit <= 1'b0;
		end else if (chainMode && (state == SAC_READOUT) && pins.sckRise) begin
			chainBit <= pins.selLvl;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			shiftReg <= RESULT_RESET;
		end else if (convDone) begin
			shiftReg <= sampleHold;
		end else if (shiftStep) begin
			shiftReg <= {shiftReg[RESULT_MSB-1:0], chainMode ? chainBit : 1'b0};
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			bitsLeft <= BITS_NONE;
		end else if (convDone) begin
			bitsLeft <= BITS_FULL;
		end else if (pins.strobeRise) begin
			bitsLeft <= BITS_NONE;
		end else if (shiftStep && (bitsLeft != BITS_NONE)) begin
			bitsLeft <= bitsLeft - 1'b1;
		end
	end

	// ****************************************************************
	// Output driver
	// ****************************************************************
	// In chip-select mode the pin is driven while strobe or select is low and
	// unsent bits remain; daisy-chain mode keeps the pin driven throughout.
	always_comb begin
		if (chainMode) begin
			next_oe = 1'b1;
		end else if ((next_state == SAC_READOUT) && (state == SAC_READOUT)) begin
			next_oe = (bitsLeft != BITS_NONE) && !(pins.strobeLvl && pins.selLvl);
		end else begin
			next_oe = 1'b0;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			serialResultOe <= 1'b0;
			serial_result_out <= 1'b0;
		end else begin
			serialResultOe <= next_oe;
			serial_result_out <= shiftReg[RESULT_MSB];
		end
	end

	// ****************************************************************
	// Status
	// ****************************************************************
	always_ff @(posedge mclk) begin
		if (rst) begin
			conversionBusy <= 1'b0;
			resultReady <= 1'b0;
			chainModeActive <= 1'b0;
		end else begin
			conversionBusy <= (next_state == SAC_CONVERT);
			resultReady <= convDone;
			chainModeActive <= chainMode;
		end
	end

endmodule // sar_adc_serial_conversion_timing

// ---- bench/sac_monitor.sv ----
// Concurrent checks on the converter pins and status outputs.
`timescale 1ns/1ps
module sac_monitor import sac_pkg::*; (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst,
	// Pins
	input wire logic convert_strobe,
	input wire logic serial_select_in,
	input wire logic serialClk,
	input wire logic serial_result_out,
	input wire logic serialResultOe,
	input wire logic [RESULT_BITS-1:0] sampleValue,
	// Status
	input wire logic conversionBusy,
	input wire logic resultReady,
	input wire logic chainModeActive
);
	logic [2:0] sckSync;
	logic [5:0] busyCnt;
	logic [4:0] fallCnt;
	logic [3:0] sinceFall;
	logic [RESULT_BITS-1:0] capVal;
	logic strobePrev;
	logic selAtRise;
	logic [6:0] pinCnt;
	logic sckFall;
	assign sckFall = sckSync[2] & ~sckSync[1];
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	always_ff @(posedge mclk) begin
		sckSync <= {sckSync[1:0], serialClk};
	end
	always_ff @(posedge mclk) begin
		busyCnt <= (rst || !conversionBusy) ? 6'h00 : busyCnt + 6'h01;
	end
	always_ff @(posedge mclk) begin
		if (conversionBusy && busyCnt == 6'h00)
			capVal <= sampleValue;
	end
	// Conversion time is taken from the strobe pin itself. A rise during a running
	// conversion is ignored by the converter, so it does not restart the count either.
	always_ff @(posedge mclk) begin
		strobePrev <= convert_strobe;
		if (rst) begin
			pinCnt <= 7'h7F;
		end else if (convert_strobe && !strobePrev && !conversionBusy) begin
			pinCnt <= 7'h01;
			selAtRise <= serial_select_in;
		end else if (pinCnt != 7'h7F) begin
			pinCnt <= pinCnt + 7'h01;
		end
	end
	// Falls are only counted while the port drives, so each chip-select frame starts from zero.
	always_ff @(posedge mclk) begin
		if (rst || !serialResultOe)
			fallCnt <= 5'h00;
		else if (sckFall)
			fallCnt <= fallCnt + 5'h01;
	end
	always_ff @(posedge mclk) begin
		if (rst || sckFall)
			sinceFall <= 4'h0;
		else if (sinceFall != 4'hF)
			sinceFall <= sinceFall + 4'h1;
	end
	sequence enableSeq;
		$rose(serialResultOe);
	endsequence
	sequence doneSeq;
		$past(conversionBusy) && resultReady;
	endsequence
	AST_CONV_TIME: assert property (resultReady
		|-> pinCnt >= CONV_MIN_CYCLES && pinCnt <= CONV_MAX_CYCLES)
		else $error("conversion time outside window");
	AST_MODE_LATCH: assert property (resultReady |-> chainModeActive == !selAtRise)
		else $error("mode does not follow select at strobe rise");
	AST_READY_PULSE: assert property (resultReady |-> doneSeq ##1 !resultReady)
		else $error("ready pulse not tied to end of conversion");
	AST_BUSY_TO_READY: assert property ($fell(conversionBusy) |-> resultReady)
		else $error("busy fell without ready");
	AST_DRIVE_AFTER_DONE: assert property ((enableSeq ##0 !chainModeActive)
		|-> !conversionBusy)
		else $error("port enabled during conversion");
	AST_MSB_FIRST: assert property ((enableSeq ##0 !chainModeActive)
		|-> ##[0:1] serial_result_out == capVal[RESULT_MSB])
		else $error("first bit is not the result msb");
	AST_BIT_HOLD: assert property ((serialResultOe && $past(serialResultOe) && !conversionBusy
		&& !chainModeActive && $changed(serial_result_out)) |-> sinceFall <= 4'h8)
		else $error("data changed without a clock fall");
	AST_CS_RELEASE: assert property ((fallCnt == 5'h10 && serialResultOe && !chainModeActive)
		|-> ##[1:8] !serialResultOe)
		else $error("port not released after last bit");
endmodule // sac_monitor

// ---- bench/sac_host_model.sv ----
// Host controller model that strobes conversions and clocks the result out.
`timescale 1ns/1ps
module sac_host_model (
	// Clock
	input wire logic mclk,
	// Converter pins
	output logic convert_strobe,
	output logic serial_select_in,
	output logic serialClk,
	input wire logic serial_result_out
);
	localparam int SCK_HALF = 5;
	initial begin
		convert_strobe = 1'b0;
		serial_select_in = 1'b1;
		serialClk = 1'b0;
	end
	task automatic waitCycles(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	// Select is set a cycle early and held past the edge so the mode is latched cleanly.
	task automatic strobe(input logic chain);
		serial_select_in = ~chain;
		waitCycles(1);
		convert_strobe = 1'b1;
		waitCycles(2);
	endtask
	task automatic restrobe();
		convert_strobe = 1'b0;
		waitCycles(4);
		convert_strobe = 1'b1;
	endtask
	// Bits are sampled late in the high phase, since the pin sync delays each new bit.
	task automatic readOut(input int n, input logic chain, input logic [15:0] link,
		output logic [31:0] got);
		got = 32'h00000000;
		convert_strobe = 1'b0;
		for (int i = 0; i < n; i++) begin
			if (chain)
				serial_select_in = (i < 16) ? link[15-i] : 1'b0;
			waitCycles(SCK_HALF);
			serialClk = ~serialClk;
			waitCycles(SCK_HALF - 1);
			got = {got[30:0], serial_result_out};
			waitCycles(1);
			serialClk = ~serialClk;
		end
		waitCycles(60);
	endtask
endmodule // sac_host_model

// ---- bench/tb.sv ----
// Self-checking bench for the conversion timer and serial result port.
`timescale 1ns/1ps
module tb import sac_pkg::*; ;
	logic mclk, rst, convert_strobe, serial_select_in, serialClk, serial_result_out;
	logic serialResultOe, conversionBusy, resultReady, chainModeActive;
	logic [RESULT_BITS-1:0] sampleValue;
	logic [31:0] got;
	int fail_count = 0;
	int checked = 0;
	int cycles = 0;
	sar_adc_serial_conversion_timing i_sar_adc_serial_conversion_timing (.mclk(mclk), .rst(rst),
		.convert_strobe(convert_strobe), .serial_select_in(serial_select_in),
		.serialClk(serialClk), .serial_result_out(serial_result_out),
		.serialResultOe(serialResultOe), .sampleValue(sampleValue),
		.conversionBusy(conversionBusy), .resultReady(resultReady),
		.chainModeActive(chainModeActive));
	sac_host_model i_sac_host_model (.mclk(mclk), .convert_strobe(convert_strobe),
		.serial_select_in(serial_select_in), .serialClk(serialClk),
		.serial_result_out(serial_result_out));
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	task automatic conclude();
		$display("checked %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// The ceiling is about three times the expected run length.
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 6000) begin
			fail_count++;
			conclude();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic convWait(input logic [15:0] value, input logic chain, input logic again);
		int start;
		int readyAt;
		readyAt = 0;
		sampleValue = value;
		i_sac_host_model.strobe(chain);
		start = cycles - 2;
		if (again) begin
			i_sac_host_model.waitCycles(8);
			sampleValue = ~value;
			i_sac_host_model.restrobe();
		end
		while (cycles - start < 44) begin
			if (resultReady === 1'b1)
				readyAt = cycles - start;
			if (cycles - start == 20)
				check("busy", {31'h0, conversionBusy}, 32'h1);
			i_sac_host_model.waitCycles(1);
		end
		check("ready time", {31'h0, readyAt >= CONV_MIN_CYCLES && readyAt <= CONV_MAX_CYCLES},
			32'h1);
		check("mode", {31'h0, chainModeActive}, {31'h0, chain});
	endtask
	task automatic csCycle(input logic [15:0] value, input logic again);
		convWait(value, 1'b0, again);
		i_sac_host_model.readOut(16, 1'b0, 16'h0000, got);
		check("cs data", {16'h0, got[15:0]}, {16'h0, value});
		check("cs release", {31'h0, serialResultOe}, 32'h0);
	endtask
	task automatic chainCycle(input logic [15:0] value, input logic [15:0] link);
		convWait(value, 1'b1, 1'b0);
		i_sac_host_model.readOut(32, 1'b1, link, got);
		check("chain data", got, {value, link});
		check("chain drive", {31'h0, serialResultOe}, 32'h1);
	endtask
	task automatic abortCycle(input logic [15:0] value);
		convWait(value, 1'b0, 1'b0);
		i_sac_host_model.readOut(8, 1'b0, 16'h0000, got);
		check("part data", {24'h0, got[7:0]}, {24'h0, value[15:8]});
		check("part drive", {31'h0, serialResultOe}, 32'h1);
		i_sac_host_model.strobe(1'b0);
		i_sac_host_model.waitCycles(6);
		check("abort release", {31'h0, serialResultOe}, 32'h0);
		check("abort busy", {31'h0, conversionBusy}, 32'h1);
		i_sac_host_model.waitCycles(40);
		i_sac_host_model.readOut(16, 1'b0, 16'h0000, got);
		check("abort data", {16'h0, got[15:0]}, {16'h0, value});
	endtask
	initial begin
		rst = 1'b1;
		sampleValue = 16'h0000;
		repeat (16) @(posedge mclk);
		#1;
		rst = 1'b0;
		i_sac_host_model.waitCycles(4);
		check("idle drive", {31'h0, serialResultOe}, 32'h0);
		csCycle(16'hA5C3, 1'b0);
		csCycle(16'h8001, 1'b0);
		csCycle(16'h3C5A, 1'b1);
		chainCycle(16'hF00F, 16'h9A6B);
		csCycle(16'hFFFF, 1'b0);
		abortCycle(16'h5AA5);
		conclude();
	end
endmodule // tb
bind sar_adc_serial_conversion_timing sac_monitor i_sac_monitor (.mclk(mclk), .rst(rst),
	.convert_strobe(convert_strobe), .serial_select_in(serial_select_in),
	.serialClk(serialClk), .serial_result_out(serial_result_out),
	.serialResultOe(serialResultOe), .sampleValue(sampleValue),
	.conversionBusy(conversionBusy), .resultReady(resultReady),
	.chainModeActive(chainModeActive));
